// *** logic/memory_map_control.sv ***
// memory map control register with an AXI4-Lite slave port
`default_nettype none
`include "memory_map_control_map.svh"

module memory_map_control
  import memory_map_control_pkg::*;
#(
  parameter bit LARGE_FLASH = 1'b1
) (
  // clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        SRST_IN,
  // axi4-lite write address and data
  input  wire logic [11:0] AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output var  logic        AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output var  logic        WREADY_OUT,
  // axi4-lite write response
  output var  logic [1:0]  BRESP_OUT,
  output var  logic        BVALID_OUT,
  input  wire logic        BREADY_IN,
  // axi4-lite read
  input  wire logic [11:0] ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output var  logic        ARREADY_OUT,
  output var  logic [31:0] RDATA_OUT,
  output var  logic [1:0]  RRESP_OUT,
  output var  logic        RVALID_OUT,
  input  wire logic        RREADY_IN,
  // memory system controls
  output var  logic        UNIFIED_MAP_ENABLE_OUT,
  output var  logic [1:0]  FLASH_BANK_SELECT_OUT,
  output var  logic [17:0] FLASH_BANK_BASE_OUT,
  output var  logic        INSTR_CACHE_OFF_OUT,
  output var  logic        CACHE_INVALIDATE_OUT
);

  localparam logic [7:0] RESET_VAL = LARGE_FLASH ? `MMC_RESET_LARGE : `MMC_RESET_SMALL;
  localparam logic [7:0] WR_MASK   = LARGE_FLASH ? `MMC_MASK_LARGE : `MMC_MASK_SMALL;

  logic [7:0]  reg_q, reg_d;
  logic        aw_got_q, aw_got_d;
  logic        w_got_q, w_got_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [7:0]  wbyte_q, wbyte_d;
  logic        wstrb0_q, wstrb0_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  rd_state_t   rd_q, rd_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  map_cfg_t    cfg_q, cfg_d;
  logic [17:0] base_q, base_d;
  logic        inval_q, inval_d;
  logic        do_write;
  // read handshake flags kept as flops so the bus outputs never glitch
  logic        arready_q, arready_d;
  logic        rvalid_q, rvalid_d;

  // write path: address and data are taken in either order, response after both
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wbyte_d  = wbyte_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    reg_d    = reg_q;
    do_write = 1'b0;
    if (AWVALID_IN && !aw_got_q && !bvalid_q) begin
      aw_got_d = 1'b1;
      awaddr_d = AWADDR_IN;
    end
    if (WVALID_IN && !w_got_q && !bvalid_q) begin
      w_got_d  = 1'b1;
      wbyte_d  = WDATA_IN[7:0];
      wstrb0_d = WSTRB_IN[0];
    end
    if (aw_got_q && w_got_q) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      // only the one word decodes; anything else answers with an error and leaves the register alone
      if (awaddr_q[11:2] == 10'(`MMC_REG_ADDR >> 2)) begin
        bresp_d  = `MMC_RESP_OKAY;
        do_write = wstrb0_q;
      end else begin
        bresp_d = `MMC_RESP_SLVERR;
      end
    end
    // a new address or data word is held off until the pending response is taken
    if (bvalid_q && BREADY_IN) begin
      bvalid_d = 1'b0;
    end
    // bits 7, 3 and 2 ignore writes (only bit 7 in the small variant); reserved bit 0 stays writable
    // small variant keeps bank bits writable storage only
    if (do_write) begin
      reg_d = (wbyte_q & WR_MASK) | (RESET_VAL & ~WR_MASK);
    end
  end

  // read path: one read at a time, answer one cycle after the address
  always_comb begin
    rd_d    = rd_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (rd_q)
      RD_IDLE: begin
        if (ARVALID_IN) begin
          rd_d = RD_RESP;
          if (ARADDR_IN[11:2] == 10'(`MMC_REG_ADDR >> 2)) begin
            rdata_d = {24'h000000, reg_q};
            rresp_d = `MMC_RESP_OKAY;
          end else begin
            rdata_d = 32'h00000000;
            rresp_d = `MMC_RESP_SLVERR;
          end
        end
      end
      RD_RESP: begin
        if (RREADY_IN) begin
          rd_d = RD_IDLE;
        end
      end
      default: begin
        rd_d = RD_IDLE;
      end
    endcase
    // ready only while idle, so a read is taken at the edge where valid and ready are both high
    arready_d = (rd_d == RD_IDLE);
    rvalid_d  = (rd_d == RD_RESP);
  end

  // memory system view of the register
  // the outputs trail the register by one cycle, well before any following access
  always_comb begin
    cfg_d.unified   = reg_q[`MMC_BIT_UNIFIED];
    cfg_d.bank      = LARGE_FLASH ? reg_q[`MMC_BIT_BANK_HI:`MMC_BIT_BANK_LO] : 2'b00;
    cfg_d.cache_off = reg_q[`MMC_BIT_CACHE_OFF];
    // physical base of the upper window
    base_d          = 18'({cfg_d.bank, 15'h0000});
    // one-cycle invalidate on the rising edge of the cache-off bit
    inval_d         = reg_q[`MMC_BIT_CACHE_OFF] && !cfg_q.cache_off;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      // bank 01 (00 in the small variant) and bit 0 set out of reset
      reg_q    <= RESET_VAL;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 12'h000;
      wbyte_q  <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'b00;
      rd_q     <= RD_IDLE;
      rdata_q  <= 32'h00000000;
      rresp_q  <= 2'b00;
      cfg_q    <= '{unified: 1'b0, bank: (LARGE_FLASH ? 2'b01 : 2'b00), cache_off: 1'b0};
      base_q   <= LARGE_FLASH ? `MMC_BANK_BYTES : 18'h00000;
      inval_q  <= 1'b0;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end else begin
      // new map applies from the cycle after the register updates
      reg_q    <= reg_d;
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      awaddr_q <= awaddr_d;
      wbyte_q  <= wbyte_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rd_q     <= rd_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
      cfg_q    <= cfg_d;
      base_q   <= base_d;
      inval_q  <= inval_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
    end
  end

  // ready flags are registered states, so outputs come from flip-flops
  assign AWREADY_OUT            = aw_got_q;
  assign WREADY_OUT             = w_got_q;
  assign BVALID_OUT             = bvalid_q;
  assign BRESP_OUT              = bresp_q;
  assign ARREADY_OUT            = arready_q;
  assign RVALID_OUT             = rvalid_q;
  assign RDATA_OUT              = rdata_q;
  assign RRESP_OUT              = rresp_q;
  assign UNIFIED_MAP_ENABLE_OUT = cfg_q.unified;
  assign FLASH_BANK_SELECT_OUT  = cfg_q.bank;
  assign FLASH_BANK_BASE_OUT    = base_q;
  assign INSTR_CACHE_OFF_OUT    = cfg_q.cache_off;
  assign CACHE_INVALIDATE_OUT   = inval_q;

endmodule : memory_map_control
`default_nettype wire

// *** logic/memory_map_control_map.svh ***
// register offsets, field positions and reset values of the memory map control block
`ifndef MEMORY_MAP_CONTROL_MAP_SVH
`define MEMORY_MAP_CONTROL_MAP_SVH

// register index 0xc7 is not word aligned, so the byte address is four times it
`define MMC_REG_INDEX        8'hc7
`define MMC_REG_ADDR         12'h31c
`define MMC_BIT_UNIFIED      6
`define MMC_BIT_BANK_HI      5
`define MMC_BIT_BANK_LO      4
`define MMC_BIT_CACHE_OFF    1
`define MMC_BIT_RSVD_ONE     0
`define MMC_RESET_LARGE      8'h11
`define MMC_RESET_SMALL      8'h01
`define MMC_MASK_LARGE       8'h73
`define MMC_MASK_SMALL       8'h7f
`define MMC_RESP_OKAY        2'b00
`define MMC_RESP_SLVERR      2'b10
`define MMC_BANK_BYTES       18'h08000

`endif

// *** logic/memory_map_control_pkg.sv ***
// types shared by the memory map control block
`default_nettype none
package memory_map_control_pkg;

  typedef struct packed {
    logic       unified;
    logic [1:0] bank;
    logic       cache_off;
  } map_cfg_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_t;

endpackage : memory_map_control_pkg
`default_nettype wire

// *** dv/fetch_model.sv ***
// instruction fetch side model: turns a CODE address into a physical flash address
`default_nettype none
module fetch_model (
  input  wire logic [17:0] BANK_BASE_IN,
  input  wire logic [15:0] PROG_ADDR_IN,
  output var  logic [17:0] PHYS_ADDR_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // upper window uses the bank base
  always_comb PHYS_ADDR_OUT = PROG_ADDR_IN[15] ? BANK_BASE_IN + {3'h0, PROG_ADDR_IN[14:0]} : {2'h0, PROG_ADDR_IN};
endmodule : fetch_model
`default_nettype wire

// *** dv/memory_map_control_monitor.sv ***
// assertion checker for the memory map control block
`default_nettype none
module memory_map_control_monitor (
  input wire logic        REF_CLK_IN,
  input wire logic        SRST_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic        WVALID_IN,
  input wire logic        WREADY_OUT,
  input wire logic [1:0]  BRESP_OUT,
  input wire logic        BVALID_OUT,
  input wire logic        BREADY_IN,
  input wire logic        UNIFIED_MAP_ENABLE_OUT,
  input wire logic [1:0]  FLASH_BANK_SELECT_OUT,
  input wire logic [17:0] FLASH_BANK_BASE_OUT,
  input wire logic        INSTR_CACHE_OFF_OUT,
  input wire logic        CACHE_INVALIDATE_OUT
);
  logic [7:0] wd_q;
  logic       done;
  // data is kept from its own handshake since address and data may be taken apart
  always_ff @(posedge REF_CLK_IN) if (WVALID_IN && WREADY_OUT) wd_q <= WDATA_IN[7:0];
  assign done = BVALID_OUT && BREADY_IN && BRESP_OUT == 2'b00;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);
  chk_unified_set: assert property (done && wd_q[6] |-> ##[0:2] UNIFIED_MAP_ENABLE_OUT)
    else $error("unified mapping not set");
  chk_unified_clear: assert property (done && !wd_q[6] |-> ##[0:2] !UNIFIED_MAP_ENABLE_OUT)
    else $error("unified mapping not cleared");
  chk_bank_follow: assert property (done |-> ##[0:2] FLASH_BANK_SELECT_OUT == wd_q[5:4])
    else $error("bank select not updated");
  chk_bank_base: assert property (FLASH_BANK_BASE_OUT == {1'b0, FLASH_BANK_SELECT_OUT, 15'h0})
    else $error("bank base wrong");
  chk_reset_state: assert property ($fell(SRST_IN) |-> FLASH_BANK_SELECT_OUT == 2'b01 && !UNIFIED_MAP_ENABLE_OUT && !INSTR_CACHE_OFF_OUT)
    else $error("reset state wrong");
  chk_cache_off: assert property (done |-> ##[0:2] INSTR_CACHE_OFF_OUT == wd_q[1])
    else $error("cache off not updated");
  chk_cache_inval: assert property (WVALID_IN && WREADY_OUT && WDATA_IN[1] && !INSTR_CACHE_OFF_OUT |-> ##[0:4] CACHE_INVALIDATE_OUT)
    else $error("cache not invalidated");
  cov_write: cover property (done);
  cov_inval: cover property (CACHE_INVALIDATE_OUT);
  cov_bank3: cover property (FLASH_BANK_SELECT_OUT == 2'b11);
endmodule : memory_map_control_monitor
bind memory_map_control memory_map_control_monitor memory_map_control_monitor_i (.*);
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the memory map control block
`default_nettype none
`include "memory_map_control_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0, awr, wr_, bv, arr, rv, un, co, ci, seen_inv = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, rv_q, st = 39091;
  logic [1:0]  br, rrs, bs, bres, rres;
  logic [17:0] bb, ph;
  logic [7:0]  img;
  int          n_errors = 0, checks = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (ci) seen_inv <= 1;
  memory_map_control memory_map_control_i (.REF_CLK_IN(clk), .SRST_IN(rst), .AWADDR_IN(awa), .AWVALID_IN(awv),
    .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(4'hf), .WVALID_IN(wv), .WREADY_OUT(wr_), .BRESP_OUT(br),
    .BVALID_OUT(bv), .BREADY_IN(bq), .ARADDR_IN(ara), .ARVALID_IN(arv), .ARREADY_OUT(arr), .RDATA_OUT(rdat),
    .RRESP_OUT(rrs), .RVALID_OUT(rv), .RREADY_IN(rq), .UNIFIED_MAP_ENABLE_OUT(un), .FLASH_BANK_SELECT_OUT(bs),
    .FLASH_BANK_BASE_OUT(bb), .INSTR_CACHE_OFF_OUT(co), .CACHE_INVALIDATE_OUT(ci));
  fetch_model fetch_model_i (.BANK_BASE_IN(bb), .PROG_ADDR_IN(16'hc123), .PHYS_ADDR_OUT(ph));
  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // waits end only by the watchdog, the slave decides its own latency
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bq <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr_) wv <= 0;
    end while (!bv);
    bq <= 0;
    bres = br;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rq <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    rq <= 0;
    rv_q = rdat;
    rres = rrs;
  endtask : rd
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    rd(`MMC_REG_ADDR);
    chk("reset value", rv_q, 32'h11);
    for (int i = 0; i < 8; i++) begin
      img = (8'(xs()) & 8'h40) | {2'h0, i[1:0], 2'h0, i[2], 1'b1};
      wr(`MMC_REG_ADDR, img);
      chk("write resp", 32'(bres), 32'(`MMC_RESP_OKAY));
      rd(`MMC_REG_ADDR);
      chk("read back", rv_q, 32'(img));
      chk("unified", 32'(un), 32'(img[6]));
      chk("bank", 32'(bs), 32'(img[5:4]));
      chk("base", 32'(bb), 32'(img[5:4]) * 32'h8000);
      chk("fetch", 32'(ph), 32'(img[5:4]) * 32'h8000 + 32'h4123);
      chk("cache off", 32'(co), 32'(img[1]));
    end
    chk("invalidate", 32'(seen_inv), 32'h1);
    wr(12'h000, 8'h00);
    chk("unmapped resp", 32'(bres), 32'(`MMC_RESP_SLVERR));
    rd(`MMC_REG_ADDR);
    chk("kept", rv_q, 32'(img));
    // cache back on for normal running
    wr(`MMC_REG_ADDR, 8'h11);
    tally_and_finish();
  end
  // under a hundred cycles are needed, so this bound only trips on a hang
  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
